// [design/tts_top.sv]
// Purpose: transient trigger sequencer with list and dwell pacing
// Assumes: commands arrive as pulses written to the command register
// Notes: phase_ref is driven by logic on clk, so it is not synchronised
//
// What this block does
// RULE_01: after reset the sequencer is idle and ignores all triggers there.
// RULE_02: abort or device reset returns the sequencer to idle from any state.
// RULE_03: initiate moves idle to initiated, where a trigger can be accepted.
// RULE_04: one accepted action ends in idle; host re-initiates for each more.
// RULE_05: continuous initiation re-enters initiated after each action by itself.
// RULE_06: bus source takes the bus trigger command as trigger event.
// RULE_07: immediate source makes the trigger always true, giving repeating transients.
// RULE_08: a trigger while initiated moves the sequencer into the delay state.
// RULE_09: phase sync starts the transient only at the programmed phase angle.
// RULE_10: immediate sync passes straight to output without waiting for phase.
// RULE_11: output change loads the triggered level, then returns to idle.
// RULE_12: dwell count must match point count, or a single dwell serves all.
// RULE_13: each applied list point is held for its own dwell time.
// RULE_14: only abort or device reset leaves dwelling early; other inputs wait for dwell end.
// RULE_15: dwell end with the list complete returns to idle.
// RULE_16: dwell end, points left, single step: back to initiated for a trigger.
// RULE_17: dwell end, points left, automatic: apply the next point at once.
// RULE_18: the list store holds up to 32 points, each with its dwell.
// RULE_19: a trigger arriving during a dwell is dropped, not queued.
// RULE_20: the whole list repeats a programmed count, one after reset.
// RULE_21: in delay with phase sync, compare phase each cycle, go on match.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tts_top
  import tts_pkg::*;
#(
  parameter int unsigned TICK_CYC = DWELL_UNIT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic [PHASE_W-1:0] phase_ref,
  output logic [LEVEL_W-1:0] out_level,
  output logic out_strobe,
  output logic [2:0] seq_state
);

  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction : hit

  tts_ctrl_t ctrl_q, next_ctrl;
  tts_cmd_t cmd;
  logic [PHASE_W-1:0] angle_q, next_angle;
  logic [CNT_W-1:0] npts_q, next_npts;
  logic [CNT_W-1:0] ndw_q, next_ndw;
  logic [REP_W-1:0] nrep_q, next_nrep;
  logic [IDX_W-1:0] widx_q, next_widx;
  logic [LEVEL_W-1:0] tlevel_q, next_tlevel;
  logic [DATA_W-1:0] next_rdata;

  // sequencer state
  tts_state_t state_q, next_state;
  logic [IDX_W-1:0] point_q, next_point;
  logic [REP_W-1:0] rep_q, next_rep;
  logic [DWELL_W-1:0] dwell_left_q, next_dwell_left;
  logic [TICK_W-1:0] tick_q, next_tick;
  logic fetch_q, next_fetch;
  logic err_q, next_err;
  logic [LEVEL_W-1:0] next_out_level;
  logic next_out_strobe;

  // list store read side
  logic [LEVEL_W-1:0] lvl_rd;
  logic [DWELL_W-1:0] dw_rd;
  logic [IDX_W-1:0] dw_raddr;

  // helper terms
  logic abort_any;
  logic go;
  logic list_ok;
  logic trig_ok;
  logic phase_hit;
  logic dwell_end;
  logic last_pt;
  logic list_done;
  logic [REP_W-1:0] nrep_eff;

  // commands are one-cycle pulses decoded from the command write
  always_comb begin
    cmd = tts_cmd_t'(CMD_W'(0));
    if (wr && hit(addr, OFS_CMD)) begin
      cmd = tts_cmd_t'(wdata[CMD_W-1:0]);
    end
  end

  // ---------------------------------------------------------------
  // list store, one level and one dwell per point
  // ---------------------------------------------------------------
  // a single dwell entry serves every point, so read entry zero then
  assign dw_raddr = (ndw_q == CNT_W'(1)) ? IDX_W'(0) : point_q; // RULE_12

  tts_mem #(.W(LEVEL_W), .DEPTH(LIST_PTS), .AW(IDX_W)) u_level_mem ( // RULE_18
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .wr_en(wr && hit(addr, OFS_LLEVEL)),
    .wr_addr(widx_q),
    .wr_data(wdata[LEVEL_W-1:0]),
    .rd_addr(point_q),
    .rd_data(lvl_rd)
  );

  tts_mem #(.W(DWELL_W), .DEPTH(LIST_PTS), .AW(IDX_W)) u_dwell_mem ( // RULE_18
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .wr_en(wr && hit(addr, OFS_LDWELL)),
    .wr_addr(widx_q),
    .wr_data(wdata[DWELL_W-1:0]),
    .rd_addr(dw_raddr),
    .rd_data(dw_rd)
  );

  // ---------------------------------------------------------------
  // configuration registers and read-back
  // ---------------------------------------------------------------
  // device reset restores the control, phase angle and list count defaults as well
  always_comb begin
    next_ctrl = ctrl_q;
    next_angle = angle_q;
    next_npts = npts_q;
    next_ndw = ndw_q;
    next_nrep = nrep_q;
    next_widx = widx_q;
    next_tlevel = tlevel_q;
    if (cmd.dev_reset) begin
      next_ctrl = CTRL_RST; // RULE_10
      next_angle = ANGLE_RST;
      next_nrep = NREP_RST; // RULE_20
    end else if (wr) begin
      if (hit(addr, OFS_CTRL)) next_ctrl = tts_ctrl_t'(wdata[CTRL_W-1:0]);
      if (hit(addr, OFS_PHASE)) next_angle = wdata[PHASE_W-1:0];
      if (hit(addr, OFS_LSIZE)) begin
        next_npts = wdata[CNT_W-1:0];
        next_ndw = wdata[LSIZE_DW_LSB +: CNT_W];
      end
      if (hit(addr, OFS_LCOUNT)) next_nrep = wdata[REP_W-1:0];
      if (hit(addr, OFS_LINDEX)) next_widx = wdata[IDX_W-1:0];
      if (hit(addr, OFS_TLEVEL)) next_tlevel = wdata[LEVEL_W-1:0];
    end
  end

  // unmapped and write-only addresses read as zero
  always_comb begin
    next_rdata = '0;
    if (rd) begin
      unique case (addr)
        OFS_CTRL: next_rdata = DATA_W'(ctrl_q);
        OFS_PHASE: next_rdata = DATA_W'(angle_q);
        OFS_LSIZE: next_rdata = DATA_W'({ndw_q, 2'b00, npts_q});
        OFS_LCOUNT: next_rdata = DATA_W'(nrep_q);
        OFS_LINDEX: next_rdata = DATA_W'(widx_q);
        OFS_TLEVEL: next_rdata = DATA_W'(tlevel_q);
        OFS_STATUS: begin
          next_rdata[2:0] = state_q;
          next_rdata[STAT_ERR_BIT] = err_q;
          next_rdata[STAT_PT_LSB +: IDX_W] = point_q;
          next_rdata[STAT_REP_LSB +: REP_W] = rep_q;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
      angle_q <= ANGLE_RST;
      npts_q <= NPTS_RST;
      ndw_q <= NPTS_RST;
      nrep_q <= NREP_RST;
      widx_q <= '0;
      tlevel_q <= TLEVEL_RST;
      rdata <= '0;
    end else if (ce) begin
      ctrl_q <= next_ctrl;
      angle_q <= next_angle;
      npts_q <= next_npts;
      ndw_q <= next_ndw;
      nrep_q <= next_nrep;
      widx_q <= next_widx;
      tlevel_q <= next_tlevel;
      rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign abort_any = cmd.abort | cmd.dev_reset; // RULE_02
  assign go = cmd.init | ctrl_q.cont; // RULE_03 RULE_05
  // a bad list size is refused at initiate rather than mid-run
  assign list_ok = !ctrl_q.list_mode || ((npts_q != '0) && (npts_q <= CNT_W'(LIST_PTS)) &&
                   ((ndw_q == CNT_W'(1)) || (ndw_q == npts_q))); // RULE_12
  assign trig_ok = ctrl_q.src_imm | cmd.bus_trig; // RULE_06 RULE_07
  assign phase_hit = phase_ref == angle_q; // RULE_21
  assign dwell_end = dwell_left_q == '0;
  assign last_pt = {1'b0, point_q} == (npts_q - CNT_W'(1));
  // a count of zero would never finish, so it is run once
  assign nrep_eff = (nrep_q == '0) ? REP_W'(1) : nrep_q;
  assign list_done = last_pt && ((rep_q + REP_W'(1)) >= nrep_eff); // RULE_20

  always_comb begin
    next_state = state_q;
    next_point = point_q;
    next_rep = rep_q;
    next_dwell_left = dwell_left_q;
    next_tick = tick_q;
    next_fetch = fetch_q;
    next_err = err_q;
    next_out_level = out_level;
    next_out_strobe = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        // triggers are not looked at here
        if (go) begin // RULE_01
          if (list_ok) begin
            next_state = ST_INITIATED; // RULE_03
            next_point = '0;
            next_rep = '0;
            next_err = 1'b0;
          end else begin
            next_err = 1'b1; // RULE_12
          end
        end
      end
      ST_INITIATED: begin
        if (trig_ok) next_state = ST_DELAY; // RULE_08
      end
      ST_DELAY: begin
        if (!ctrl_q.sync_phase || phase_hit) begin // RULE_09 RULE_10 RULE_21
          next_state = ST_OUTPUT;
          next_fetch = 1'b1;
        end
      end
      ST_OUTPUT: begin
        // first cycle lets the list store present the current point
        if (fetch_q) begin
          next_fetch = 1'b0;
        end else begin
          next_out_strobe = 1'b1;
          if (ctrl_q.list_mode) begin
            next_out_level = lvl_rd; // RULE_13
            next_dwell_left = dw_rd;
            next_tick = '0;
            next_state = ST_DWELL;
          end else begin
            next_out_level = tlevel_q; // RULE_11
            next_state = ctrl_q.cont ? ST_INITIATED : ST_IDLE; // RULE_04 RULE_05
          end
        end
      end
      ST_DWELL: begin
        // triggers and commands other than abort and device reset have no effect until the dwell runs out
        if (!dwell_end) begin // RULE_14 RULE_19
          if (tick_q == TICK_LAST) begin
            next_tick = '0;
            next_dwell_left = dwell_left_q - DWELL_W'(1); // RULE_13
          end else begin
            next_tick = tick_q + TICK_W'(1);
          end
        end else if (list_done) begin
          next_point = '0;
          next_rep = '0;
          next_state = ctrl_q.cont ? ST_INITIATED : ST_IDLE; // RULE_15 RULE_05
        end else begin
          if (last_pt) begin
            next_point = '0;
            next_rep = rep_q + REP_W'(1); // RULE_20
          end else begin
            next_point = point_q + IDX_W'(1);
          end
          if (ctrl_q.step_once) begin
            next_state = ST_INITIATED; // RULE_16
          end else begin
            next_state = ST_OUTPUT; // RULE_17
            next_fetch = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // abort wins over every transition above
    if (abort_any) begin
      next_state = ST_IDLE; // RULE_02
      next_fetch = 1'b0;
      next_out_strobe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE; // RULE_01
      point_q <= '0;
      rep_q <= '0;
      dwell_left_q <= '0;
      tick_q <= '0;
      fetch_q <= 1'b0;
      err_q <= 1'b0;
      out_level <= TLEVEL_RST;
      out_strobe <= 1'b0;
    end else if (ce) begin
      state_q <= next_state;
      point_q <= next_point;
      rep_q <= next_rep;
      dwell_left_q <= next_dwell_left;
      tick_q <= next_tick;
      fetch_q <= next_fetch;
      err_q <= next_err;
      out_level <= next_out_level;
      out_strobe <= next_out_strobe;
    end
  end

  assign seq_state = state_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_apply_single;
    ce && state_q == ST_OUTPUT && !fetch_q && !ctrl_q.list_mode && !abort_any;
  endsequence

  sequence s_dwell_out;
    ce && state_q == ST_DWELL && dwell_end && !list_done && !abort_any;
  endsequence

  a_abort_to_idle: assert property (ce && abort_any |=> state_q == ST_IDLE) // RULE_02
    else $error("abort did not return to idle");
  a_idle_holds: assert property (ce && state_q == ST_IDLE && !go |=> state_q == ST_IDLE) // RULE_01
    else $error("idle left without initiate");
  a_init_enters: assert property ( // RULE_03
    ce && state_q == ST_IDLE && go && list_ok && !abort_any |=> state_q == ST_INITIATED)
    else $error("initiate not taken");
  a_trig_delay: assert property ( // RULE_08
    ce && state_q == ST_INITIATED && trig_ok && !abort_any |=> state_q == ST_DELAY)
    else $error("trigger did not reach delay");
  a_phase_wait: assert property ( // RULE_09
    ce && state_q == ST_DELAY && ctrl_q.sync_phase && !phase_hit && !abort_any
    |=> state_q == ST_DELAY)
    else $error("delay left before phase match");
  a_sync_direct: assert property ( // RULE_10
    ce && state_q == ST_DELAY && (!ctrl_q.sync_phase || phase_hit) && !abort_any
    |=> state_q == ST_OUTPUT)
    else $error("delay did not pass to output");
  a_single_level: assert property ( // RULE_11
    s_apply_single |=> out_strobe && out_level == $past(tlevel_q)
    && state_q == ($past(ctrl_q.cont) ? ST_INITIATED : ST_IDLE))
    else $error("triggered level or return wrong");
  a_dwell_hold: assert property ( // RULE_14
    ce && state_q == ST_DWELL && !dwell_end && !abort_any |=> state_q == ST_DWELL)
    else $error("dwell left early");
  a_step_once: assert property ( // RULE_16
    s_dwell_out ##0 ctrl_q.step_once |=> state_q == ST_INITIATED)
    else $error("single step did not wait for trigger");
  // an abort in the fetch cycle may legally cut the step short
  a_step_auto: assert property ( // RULE_17
    s_dwell_out ##0 !ctrl_q.step_once
    |=> state_q == ST_OUTPUT ##1 (state_q == ST_OUTPUT || $past(abort_any)))
    else $error("automatic step did not output next point");
  a_list_end: assert property ( // RULE_15
    ce && state_q == ST_DWELL && dwell_end && list_done && !abort_any
    && !ctrl_q.cont |=> state_q == ST_IDLE)
    else $error("complete list did not go idle");

endmodule : tts_top
`default_nettype wire

// [design/tts_pkg.sv]
// Purpose: shared constants and types of the transient trigger sequencer
// Assumes: 40 MHz clock, byte-addressed register port with 32-bit words
// Notes: dwell times are counted in whole milliseconds
package tts_pkg;

  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LEVEL_W = 16;
  localparam int DWELL_W = 24;
  localparam int PHASE_W = 9;
  localparam int LIST_PTS = 32;
  localparam int IDX_W = 5;
  localparam int CNT_W = 6;
  localparam int REP_W = 16;
  localparam int CTRL_W = 5;
  localparam int CMD_W = 4;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LSIZE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LCOUNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LINDEX = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LLEVEL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LDWELL = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TLEVEL = 8'h24;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int LSIZE_DW_LSB = 8;
  localparam int STAT_ERR_BIT = 3;
  localparam int STAT_PT_LSB = 4;
  localparam int STAT_REP_LSB = 16;
  localparam logic [CNT_W-1:0] NPTS_RST = 6'h01;
  localparam logic [REP_W-1:0] NREP_RST = 16'h0001;
  localparam logic [PHASE_W-1:0] ANGLE_RST = 9'h000;
  localparam logic [LEVEL_W-1:0] TLEVEL_RST = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int DWELL_UNIT_NS = 1000000;
  localparam int DWELL_UNIT_CYC = (DWELL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // packed carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic list_mode;
    logic step_once;
    logic sync_phase;
    logic src_imm;
    logic cont;
  } tts_ctrl_t;

  localparam tts_ctrl_t CTRL_RST = 5'h00;

  typedef struct packed {
    logic dev_reset;
    logic abort;
    logic bus_trig;
    logic init;
  } tts_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INITIATED = 3'b001,
    ST_DELAY = 3'b010,
    ST_OUTPUT = 3'b011,
    ST_DWELL = 3'b100
  } tts_state_t;

endpackage : tts_pkg

// [design/tts_mem.sv]
// Purpose: small list store, one write port and one registered read port
// Assumes: read address is stable one cycle ahead of use
// Notes: array content has no reset, only the read register does
`timescale 1ns/1ps
`default_nettype none
module tts_mem #(
  parameter int W = 16,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_rd_data;

  // read data come from a register, one cycle after the address
  always_comb begin
    next_rd_data = mem[rd_addr];
  end

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
    end else if (ce) begin
      rd_data <= next_rd_data;
    end
  end

endmodule : tts_mem
`default_nettype wire

// [verif/tts_host.sv]
// Purpose: host side model that drives the register port of the sequencer
// Assumes: signals change right after a rising edge; the device never stalls
// Notes: a write ends on the edge that samples it; the next access starts one edge later
`timescale 1ns/1ps
`default_nettype none
module tts_host
  import tts_pkg::*;
(
  input wire logic clk,
  output var logic [ADDR_W-1:0] addr,
  output var logic [DATA_W-1:0] wdata,
  output var logic wr,
  output var logic rd,
  input wire logic [DATA_W-1:0] rdata
);
  // ------------------------------------------------------------
  // idle bus at time zero
  // ------------------------------------------------------------
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one-cycle write strobe, held until the sampling edge
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : write_reg

  // read data is valid only in the cycle after the strobe, so take it mid-cycle
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : read_reg
endmodule : tts_host
`default_nettype wire

// [verif/tts_top_bench.sv]
// Purpose: self-checking bench for the transient trigger sequencer
// Assumes: short dwell tick of 4 cycles per unit
// Notes: phase reference is a free-running 0..359 counter
`timescale 1ns/1ps
`default_nettype none
module tts_top_bench
  import tts_pkg::*;
;
  localparam int TICK = 4;
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [LEVEL_W-1:0] lvl;
    logic [PHASE_W-1:0] ang;
  } tts_row_t;
  // bus source, immediate source, then phase sync at angle 90 and at the top of the angle range, 359
  localparam tts_row_t ROWS [4] = '{'{5'h00, 16'h1234, 9'h000}, '{5'h02, 16'hABCD, 9'h000},
    '{5'h04, 16'h0F0F, 9'h05A}, '{5'h06, 16'h8001, 9'h167}};
  localparam logic [ADDR_W-1:0] RA [7] = '{OFS_CTRL, OFS_PHASE, OFS_LSIZE, OFS_LCOUNT,
    OFS_TLEVEL, OFS_CMD, 8'h3C};
  localparam logic [DATA_W-1:0] RV [7] = '{32'h0, 32'h0, 32'h101, 32'h1, 32'h0, 32'h0, 32'h0};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic wr;
  logic rd;
  logic [PHASE_W-1:0] phase_ref = 9'h000;
  logic [LEVEL_W-1:0] out_level;
  logic out_strobe;
  logic [2:0] seq_state;
  logic [PHASE_W-1:0] hit_ph;
  logic [DATA_W-1:0] d;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_last = 0;
  int cnt;

  // ------------------------------------------------------------
  // clock, phase reference and observers
  // ------------------------------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end
  // phase seen while delaying; the last one is the match value
  always @(posedge clk) begin
    phase_ref <= (phase_ref == 9'h167) ? 9'h000 : phase_ref + 9'h001;
    cyc <= cyc + 1;
    if (seq_state == ST_DELAY) hit_ph <= phase_ref;
  end

  tts_top #(.TICK_CYC(TICK)) tts_top_i (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .phase_ref(phase_ref),
    .out_level(out_level), .out_strobe(out_strobe), .seq_state(seq_state));
  tts_host tts_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    tts_host_i.write_reg(a, v);
  endtask : w
  // a lost strobe must not hang the run
  task automatic wait_strobe;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (out_strobe === 1'b1) return;
    end
    n_fail++;
    finish_test();
  endtask : wait_strobe
  // a single dwell entry is written only at point 0, so others stay unwritten
  task automatic set_list(input int n, input int nd, input logic [DATA_W-1:0] dw);
    for (int i = 0; i < n; i++) begin
      w(OFS_LINDEX, 32'(i));
      w(OFS_LLEVEL, 32'h100 + 32'(i));
      if (i == 0 || nd > 1) w(OFS_LDWELL, dw);
    end
    w(OFS_LSIZE, 32'((nd << LSIZE_DW_LSB) | n));
  endtask : set_list

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(seq_state, ST_IDLE);
    // reset values, write-only command and an unmapped address
    foreach (RA[i]) begin
      tts_host_i.read_reg(RA[i], d);
      chk(d, RV[i]);
    end
    w(OFS_CMD, 32'h2);
    repeat (4) @(negedge clk);
    chk(seq_state, ST_IDLE);
    // one triggered action per row, each with a fresh initiate
    foreach (ROWS[k]) begin
      w(OFS_TLEVEL, 32'(ROWS[k].lvl));
      w(OFS_PHASE, 32'(ROWS[k].ang));
      w(OFS_CTRL, 32'(ROWS[k].ctrl));
      w(OFS_CMD, 32'h1);
      if (!ROWS[k].ctrl[1]) begin
        #1 chk(seq_state, ST_INITIATED);
        w(OFS_CMD, 32'h2);
        #1 chk(seq_state, ST_DELAY);
      end
      wait_strobe();
      chk(out_level, 32'(ROWS[k].lvl));
      chk(seq_state, ST_IDLE);
      if (ROWS[k].ctrl[2]) chk(hit_ph, 32'(ROWS[k].ang));
    end
    // continuous immediate triggering, then device reset
    w(OFS_CTRL, 32'h3);
    cnt = 0;
    repeat (40) begin
      @(negedge clk);
      if (out_strobe === 1'b1) cnt++;
    end
    chk(32'(cnt >= 4), 32'h1);
    w(OFS_CMD, 32'h8);
    #1 chk(seq_state, ST_IDLE);
    tts_host_i.read_reg(OFS_CTRL, d);
    chk(d, 32'h0);
    // automatic list, one shared dwell, run twice
    set_list(3, 1, 32'h2);
    w(OFS_LCOUNT, 32'h2);
    w(OFS_CTRL, 32'h12);
    w(OFS_CMD, 32'h1);
    for (int j = 0; j < 6; j++) begin
      wait_strobe();
      chk(out_level, 32'h100 + 32'(j % 3));
      if (j > 0) chk(32'(cyc - t_last), 32'(2 * TICK + 3));
      t_last = cyc;
    end
    repeat (2 * TICK + 2) @(negedge clk);
    chk(seq_state, ST_IDLE);
    // trigger paced list; early triggers must be dropped
    set_list(2, 2, 32'h2);
    w(OFS_LCOUNT, 32'h1);
    w(OFS_CTRL, 32'h18);
    w(OFS_CMD, 32'h1);
    w(OFS_CMD, 32'h2);
    wait_strobe();
    chk(out_level, 32'h100);
    w(OFS_CMD, 32'h2);
    w(OFS_CMD, 32'h1);
    repeat (12) @(negedge clk);
    chk(seq_state, ST_INITIATED);
    w(OFS_CMD, 32'h2);
    wait_strobe();
    chk(out_level, 32'h101);
    w(OFS_CMD, 32'h4);
    #1 chk(seq_state, ST_IDLE);
    // dwell count that fits neither rule, then too many points
    w(OFS_LSIZE, 32'h203);
    w(OFS_CMD, 32'h1);
    #1 chk(seq_state, ST_IDLE);
    tts_host_i.read_reg(OFS_STATUS, d);
    chk(32'(d[STAT_ERR_BIT]), 32'h1);
    w(OFS_LSIZE, 32'h121);
    w(OFS_CMD, 32'h1);
    #1 chk(seq_state, ST_IDLE);
    // a full list is accepted
    set_list(32, 1, 32'h0);
    w(OFS_CMD, 32'h1);
    #1 chk(seq_state, ST_INITIATED);
    // a low clock enable freezes the sequencer, so this trigger is lost
    @(posedge clk) ce <= 1'b0;
    w(OFS_CMD, 32'h2);
    #1 chk(seq_state, ST_INITIATED);
    @(posedge clk) ce <= 1'b1;
    #1 chk(seq_state, ST_INITIATED);
    w(OFS_CMD, 32'h4);
    finish_test();
  end
endmodule : tts_top_bench
`default_nettype wire
